// File: supply_temp_sense_monitor.sv
// Voltage sense, thermal shutdown and supply monitor control with AXI4-Lite
// ==========================================================================
// Operation
// - Sense stage runs only with stage enable set to voltage code.
// - Conversion loops charge to level, fixed discharge, one pulse per loop.
// - Each count pulse is stretched to a fixed length.
// - Start bit one begins conversion, zero stops; both timers start.
// - Timer2 compare match ends conversion and captures timer3.
// - Channel field is one-hot, five sources, zero selects none.
// - Unused bits of channel and thermal registers read zero.
// - Thermal shutdown armed while disable bit is zero.
// - Disable bit clears on every reset.
// - Overtemperature sets thermal reset flag only when armed.
// - Armed overtemperature forces reset and disables outputs at once.
// - Supply monitor works only while its enable bit is one.
// - Three-bit field picks one of eight supply thresholds.
// - Supply flag shows supply below selected threshold.
// - Mask and global enable gate the flag onto interrupt request.
// - Flag clears on vector execution or writing one.
// - One bit selects brown-out level; comparator applies hysteresis.
// - Set brown-out flag generates internal reset.
module supply_temp_sense_monitor
  import sense_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        level_reached,
  input  wire logic        over_temp,
  input  wire logic        supply_below,
  input  wire logic        brownout_below,
  input  wire logic        timer2_match,
  input  wire logic        global_irq_enable,
  input  wire logic        supply_vector_ack,
  output analog_ctrl_type  analog_ctrl_q,
  output logic             sense_pulse_out,
  output logic             timers_start_q,
  output logic             timer3_capture_q,
  output logic             supply_irq_q,
  output logic             internal_reset_q,
  output logic             shutdown_q
);

  // ==========================================================================
  // Decode helpers
  function automatic logic is_onehot5(input logic [4:0] v);
    return (v != 5'h00) && ((v & (v - 5'h01)) == 5'h00);
  endfunction : is_onehot5

  // ==========================================================================
  // Synchronised analog inputs
  logic       level_s, temp_s, supply_s, brown_s;
  logic [3:0] async_bus;
  logic [3:0] sync_bus;
  assign async_bus = {brownout_below, supply_below, over_temp, level_reached};
  assign {brown_s, supply_s, temp_s, level_s} = sync_bus;
  for (genvar i = 0; i < 4; i++) begin : g_sync
    sync3 u_sync (
      .clk      (clk),
      .resetn   (resetn),
      .async_in (async_bus[i]),
      .level_q  (sync_bus[i])
    );
  end

  // ==========================================================================
  // Register state
  logic       meas_start_q;
  logic [1:0] stage_en_q;
  logic [4:0] channel_q;
  logic       shutdown_dis_q;
  logic       supply_en_q;
  logic [2:0] level_sel_q;
  logic       supply_mask_q;
  logic       supply_flag_q;
  logic       brown_ls_q;
  logic       brown_pd_q;
  logic       thermal_flag_q;
  logic       brown_flag_q;
  logic       stage_on;
  logic       armed;
  logic       conv_end;
  assign stage_on = (stage_en_q == STAGE_VOLTAGE_CODE);
  assign armed    = !shutdown_dis_q;

  // ==========================================================================
  // AXI4-Lite write channel
  logic       aw_held_q;
  logic       w_held_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic       wr_fire;
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready;
      s_axi_wready  <= !w_held_q && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q[1:0] == 2'h0 &&
                         awaddr_q <= RESET_STATUS_OFFSET) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  logic wr_ok;
  assign wr_ok = wr_fire && wstrb_q[0];

  // ==========================================================================
  // Control registers
  always_ff @(posedge clk) begin
    if (!resetn || internal_reset_q) begin
      meas_start_q   <= 1'b0;
      stage_en_q     <= 2'h0;
      channel_q      <= CHANNEL_NONE;
      shutdown_dis_q <= 1'b0;
      supply_en_q    <= 1'b0;
      level_sel_q    <= 3'h0;
      supply_mask_q  <= 1'b0;
      brown_ls_q     <= 1'b0;
      brown_pd_q     <= 1'b0;
    end else begin
      if (conv_end) begin
        meas_start_q <= 1'b0;
      end
      if (wr_ok) begin
        case (awaddr_q)
          SENSOR_CTRL_OFFSET: begin
            meas_start_q <= wdata_q[MEAS_START_POS];
            stage_en_q   <= wdata_q[STAGE_EN_LSB +: 2];
          end
          CHANNEL_SEL_OFFSET:  channel_q <= wdata_q[4:0];
          THERMAL_CTRL_OFFSET: shutdown_dis_q <= wdata_q[0];
          SUPPLY_CTRL_OFFSET: begin
            supply_en_q   <= wdata_q[SUPPLY_EN_POS];
            level_sel_q   <= wdata_q[LEVEL_SEL_LSB +: 3];
            supply_mask_q <= wdata_q[SUPPLY_MASK_POS];
            brown_pd_q    <= wdata_q[6];
            brown_ls_q    <= wdata_q[BROWNOUT_LS_POS];
          end
          default: ;
        endcase
      end
    end
  end

  // ==========================================================================
  // Flags: hardware set wins over software clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      supply_flag_q  <= 1'b0;
      thermal_flag_q <= 1'b0;
      brown_flag_q   <= 1'b0;
    end else begin
      if (supply_en_q && supply_s) begin
        supply_flag_q <= 1'b1;
      end else if (supply_vector_ack ||
                   (wr_ok && awaddr_q == SUPPLY_CTRL_OFFSET &&
                    wdata_q[SUPPLY_FLAG_POS])) begin
        supply_flag_q <= 1'b0;
      end
      if (armed && temp_s) begin
        thermal_flag_q <= 1'b1;
      end else if (wr_ok && awaddr_q == RESET_STATUS_OFFSET &&
                   wdata_q[THERMAL_FLAG_POS]) begin
        thermal_flag_q <= 1'b0;
      end
      if (brown_s) begin
        brown_flag_q <= 1'b1;
      end else if (wr_ok && awaddr_q == RESET_STATUS_OFFSET &&
                   wdata_q[BROWNOUT_FL_POS]) begin
        brown_flag_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Conversion sequencer
  conv_state_type state_q;
  logic [7:0]     dis_cnt_q;
  logic           loop_pulse;
  assign conv_end = (state_q != CONV_IDLE) && timer2_match;
  assign loop_pulse = (state_q == CONV_CHARGE) && level_s;
  always_ff @(posedge clk) begin
    if (!resetn || internal_reset_q) begin
      state_q   <= CONV_IDLE;
      dis_cnt_q <= 8'h00;
    end else if (!meas_start_q || !stage_on || conv_end) begin
      state_q <= CONV_IDLE;
    end else begin
      case (state_q)
        CONV_IDLE: state_q <= CONV_CHARGE;
        CONV_CHARGE: begin
          if (level_s) begin
            state_q   <= CONV_DISCHARGE;
            dis_cnt_q <= 8'(DISCHARGE_CYCLES);
          end
        end
        CONV_DISCHARGE: begin
          if (dis_cnt_q > 8'h01) begin
            dis_cnt_q <= dis_cnt_q - 8'h01;
          end else begin
            state_q <= CONV_CHARGE;
          end
        end
        default:   state_q <= CONV_IDLE;
      endcase
    end
  end
  pulse_stretch u_stretch (
    .clk     (clk),
    .resetn  (resetn),
    .trigger (loop_pulse),
    .pulse_q (sense_pulse_out)
  );

  // ==========================================================================
  // Outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      analog_ctrl_q    <= '0;
      timers_start_q   <= 1'b0;
      timer3_capture_q <= 1'b0;
      supply_irq_q     <= 1'b0;
      internal_reset_q <= 1'b0;
      shutdown_q       <= 1'b0;
    end else begin
      analog_ctrl_q.stage_on <= stage_on && !shutdown_q;
      analog_ctrl_q.charging <= (state_q == CONV_CHARGE);
      analog_ctrl_q.channel  <= (stage_on && is_onehot5(channel_q)) ?
                                channel_q : CHANNEL_NONE;
      analog_ctrl_q.supply_level   <= level_sel_q;
      analog_ctrl_q.supply_on      <= supply_en_q;
      analog_ctrl_q.brownout_level <= brown_ls_q;
      analog_ctrl_q.thermal_armed  <= armed;
      timers_start_q   <= meas_start_q && stage_on &&
                          (state_q == CONV_IDLE);
      timer3_capture_q <= conv_end;
      supply_irq_q     <= supply_flag_q && supply_mask_q &&
                          global_irq_enable;
      internal_reset_q <= brown_flag_q ||
                          (armed && temp_s);
      shutdown_q       <= armed && temp_s;
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      SENSOR_CTRL_OFFSET:  rd_word[2:0] = {stage_en_q, meas_start_q};
      CHANNEL_SEL_OFFSET:  rd_word[4:0] = channel_q;
      THERMAL_CTRL_OFFSET: rd_word[0]   = shutdown_dis_q;
      SUPPLY_CTRL_OFFSET:  rd_word[7:0] = {brown_ls_q, brown_pd_q,
                                           supply_flag_q, supply_mask_q,
                                           level_sel_q, supply_en_q};
      RESET_STATUS_OFFSET: rd_word[1:0] = {brown_flag_q, thermal_flag_q};
      default:             rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= (s_axi_araddr[1:0] == 2'h0 &&
                          s_axi_araddr <= RESET_STATUS_OFFSET) ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : supply_temp_sense_monitor

// File: sense_pkg.sv
// Package with register map, field layouts and timing for the sense monitor
package sense_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] SENSOR_CTRL_OFFSET   = 8'h00;
  localparam logic [7:0] CHANNEL_SEL_OFFSET   = 8'h04;
  localparam logic [7:0] THERMAL_CTRL_OFFSET  = 8'h08;
  localparam logic [7:0] SUPPLY_CTRL_OFFSET   = 8'h0c;
  localparam logic [7:0] RESET_STATUS_OFFSET  = 8'h10;

  // ==========================================================================
  // Field positions
  localparam int MEAS_START_POS   = 0;
  localparam int STAGE_EN_LSB     = 1;
  localparam int SUPPLY_EN_POS    = 0;
  localparam int LEVEL_SEL_LSB    = 1;
  localparam int SUPPLY_MASK_POS  = 4;
  localparam int SUPPLY_FLAG_POS  = 5;
  localparam int BROWNOUT_LS_POS  = 7;
  localparam int THERMAL_FLAG_POS = 0;
  localparam int BROWNOUT_FL_POS  = 1;

  // ==========================================================================
  // Codes and reset values
  localparam logic [1:0] STAGE_VOLTAGE_CODE = 2'h2;
  localparam logic [4:0] CHANNEL_NONE       = 5'h00;
  localparam logic [7:0] REG_RESET          = 8'h00;
  localparam logic [15:0] COMPARE_RESET     = 16'h0001;

  // ==========================================================================
  // Timing
  localparam int CLK_FREQ_HZ     = 40_000_000;
  localparam int PULSE_LEN_NS    = 100;
  localparam int DISCHARGE_NS    = 250;
  localparam int PULSE_CYCLES    = (PULSE_LEN_NS * (CLK_FREQ_HZ / 1_000_000)
                                    + 999) / 1000;
  localparam int DISCHARGE_CYCLES = (DISCHARGE_NS * (CLK_FREQ_HZ / 1_000_000)
                                    + 999) / 1000;

  // ==========================================================================
  // Analog interface carrier
  typedef struct packed {
    logic       stage_on;
    logic       charging;
    logic [4:0] channel;
    logic [2:0] supply_level;
    logic       supply_on;
    logic       brownout_level;
    logic       thermal_armed;
  } analog_ctrl_type;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_CHARGE,
    CONV_DISCHARGE
  } conv_state_type;

endpackage : sense_pkg

// File: pulse_stretch.sv
// Stretches a single trigger into a fixed-length count pulse
module pulse_stretch
  import sense_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic trigger,
  output logic      pulse_q
);

  // ==========================================================================
  // Length counter
  logic [7:0] count_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      count_q <= 8'h00;
      pulse_q <= 1'b0;
    end else if (trigger && count_q == 8'h00) begin
      count_q <= 8'(PULSE_CYCLES);
      pulse_q <= 1'b1;
    end else if (count_q > 8'h01) begin
      count_q <= count_q - 8'h01;
    end else begin
      count_q <= 8'h00;
      pulse_q <= 1'b0;
    end
  end

endmodule : pulse_stretch

// File: sync3.sv
// Three-flop synchroniser with agreement filter for an asynchronous level
module sync3 (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic async_in,
  output logic      level_q
);

  // ==========================================================================
  // Chain: first flop feeds only the second
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q;
      end
    end
  end

endmodule : sync3

// File: sense_chk_monitor.sv
// Concurrent checks on the sense monitor top-level outputs
module sense_chk
  import sense_pkg::*;
(
  input wire logic            clk,
  input wire logic            resetn,
  input wire logic            timer2_match,
  input wire logic            global_irq_enable,
  input wire analog_ctrl_type analog_ctrl_q,
  input wire logic            sense_pulse_out,
  input wire logic            timers_start_q,
  input wire logic            timer3_capture_q,
  input wire logic            supply_irq_q,
  input wire logic            internal_reset_q,
  input wire logic            shutdown_q
);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // One cycle of slack, stage and loop state are both registered
  AST_STAGE_OFF: assert property (
    !analog_ctrl_q.stage_on [*2] |-> !analog_ctrl_q.charging)
    else $error("charging with stage off");
  AST_CHANNEL: assert property (
    $onehot0(analog_ctrl_q.channel))
    else $error("two voltage sources joined");
  AST_PULSE_LEN: assert property (
    $rose(sense_pulse_out) |-> sense_pulse_out [*4] ##1 !sense_pulse_out)
    else $error("count pulse length wrong");
  AST_TIMERS: assert property (
    timers_start_q |-> analog_ctrl_q.stage_on ||
      $past(analog_ctrl_q.stage_on))
    else $error("timers started with stage off");
  AST_CAPTURE: assert property (
    timer3_capture_q |-> $past(timer2_match) ##1 !timer3_capture_q)
    else $error("capture without match or too long");
  AST_IRQ: assert property (
    supply_irq_q |-> $past(global_irq_enable))
    else $error("supply request without global enable");
  AST_ARMED: assert property (
    shutdown_q |-> analog_ctrl_q.thermal_armed ||
      $past(analog_ctrl_q.thermal_armed))
    else $error("shutdown while disarmed");
  AST_SHUT_RESET: assert property (
    $rose(shutdown_q) |-> ##[0:2] internal_reset_q)
    else $error("shutdown without internal reset");
  AST_SHUT_STAGE: assert property (
    shutdown_q [*4] |-> !analog_ctrl_q.stage_on)
    else $error("stage still on in shutdown");
endmodule : sense_chk

bind supply_temp_sense_monitor sense_chk chk (
  .clk, .resetn, .timer2_match, .global_irq_enable, .analog_ctrl_q,
  .sense_pulse_out, .timers_start_q, .timer3_capture_q, .supply_irq_q,
  .internal_reset_q, .shutdown_q
);

// File: tb.sv
// Self-checking testbench of the supply and temperature sense monitor
module tb;
  import sense_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic            clk, resetn;
  logic [7:0]      s_axi_awaddr, s_axi_araddr;
  logic [31:0]     s_axi_wdata, s_axi_rdata;
  logic [3:0]      s_axi_wstrb;
  logic [1:0]      s_axi_bresp, s_axi_rresp;
  logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic            s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic            s_axi_rvalid, s_axi_rready, level_reached, over_temp;
  logic            supply_below, brownout_below, timer2_match;
  logic            global_irq_enable, supply_vector_ack, sense_pulse_out;
  logic            timers_start_q, timer3_capture_q, supply_irq_q;
  logic            internal_reset_q, shutdown_q;
  analog_ctrl_type analog_ctrl_q;
  int              mismatches, total_checks;

  supply_temp_sense_monitor DUT (.*);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(input string nm, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check("bresp", er, s_axi_bresp);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check("rresp", er, s_axi_rresp);
    if (er == 2'h0) check("rdata", ed, s_axi_rdata);
  endtask : rd

  // ==========================================================================
  // Scenarios
  task automatic reset_test;
    check("armed", 32'h1, analog_ctrl_q.thermal_armed);
    rd(CHANNEL_SEL_OFFSET, 32'h0, 2'h0);
    wr(THERMAL_CTRL_OFFSET, 32'hff, 2'h0);
    rd(THERMAL_CTRL_OFFSET, 32'h1, 2'h0);
    check("armed", 32'h0, analog_ctrl_q.thermal_armed);
    wr(8'h20, 32'h1, 2'h2);
    rd(8'h06, 32'h0, 2'h2);
  endtask : reset_test

  task automatic chan_test;
    // Reference one, reference two, bandgap, then temperature and third
    logic [4:0] order [5] = '{5'h04, 5'h08, 5'h01, 5'h02, 5'h10};
    wr(SENSOR_CTRL_OFFSET, 32'h4, 2'h0);
    for (int i = 0; i < 5; i++) begin
      wr(CHANNEL_SEL_OFFSET, 32'h0, 2'h0);
      wr(CHANNEL_SEL_OFFSET, 32'(order[i]), 2'h0);
      settle(3);
      check("channel", 32'(order[i]), analog_ctrl_q.channel);
    end
    wr(CHANNEL_SEL_OFFSET, 32'h0, 2'h0);
    wr(CHANNEL_SEL_OFFSET, 32'hff, 2'h0);
    rd(CHANNEL_SEL_OFFSET, 32'h1f, 2'h0);
    check("channel", 32'h0, analog_ctrl_q.channel);
    wr(CHANNEL_SEL_OFFSET, 32'h0, 2'h0);
  endtask : chan_test

  task automatic conv_test;
    int n;
    fork
      wr(SENSOR_CTRL_OFFSET, 32'h5, 2'h0);
      for (n = 0; n < 20 && timers_start_q !== 1'b1; n++) @(negedge clk);
    join
    check("timers_start", 32'h1, n < 20);
    settle(2);
    check("stage_on", 32'h1, analog_ctrl_q.stage_on);
    check("charging", 32'h1, analog_ctrl_q.charging);
    @(posedge clk) level_reached <= 1'b1;
    for (n = 0; n < 20 && sense_pulse_out !== 1'b1; n++) @(negedge clk);
    check("pulse_seen", 32'h1, n < 20);
    @(posedge clk) level_reached <= 1'b0;
    for (n = 0; n < 20 && sense_pulse_out === 1'b1; n++) @(negedge clk);
    check("pulse_len", PULSE_CYCLES, n);
    @(posedge clk) timer2_match <= 1'b1;
    @(posedge clk) timer2_match <= 1'b0;
    for (n = 0; n < 8 && timer3_capture_q !== 1'b1; n++) @(negedge clk);
    check("capture", 32'h1, n < 8);
    rd(SENSOR_CTRL_OFFSET, 32'h4, 2'h0);
    wr(SENSOR_CTRL_OFFSET, 32'h3, 2'h0);
    settle(3);
    check("stage_on", 32'h0, analog_ctrl_q.stage_on);
    wr(SENSOR_CTRL_OFFSET, 32'h0, 2'h0);
  endtask : conv_test

  task automatic supply_test;
    for (int l = 0; l < 8; l++) begin
      wr(SUPPLY_CTRL_OFFSET, 32'h11 | (32'(l) << 1), 2'h0);
      settle(3);
      check("level", 32'(l), analog_ctrl_q.supply_level);
    end
    check("supply_on", 32'h1, analog_ctrl_q.supply_on);
    @(posedge clk) supply_below <= 1'b1;
    global_irq_enable <= 1'b1;
    settle(8);
    check("irq", 32'h1, supply_irq_q);
    rd(SUPPLY_CTRL_OFFSET, 32'h3f, 2'h0);
    @(posedge clk) global_irq_enable <= 1'b0;
    settle(3);
    check("irq", 32'h0, supply_irq_q);
    @(posedge clk) supply_below <= 1'b0;
    settle(8);
    wr(SUPPLY_CTRL_OFFSET, 32'h3f, 2'h0);
    rd(SUPPLY_CTRL_OFFSET, 32'h1f, 2'h0);
    @(posedge clk) supply_below <= 1'b1;
    settle(8);
    @(posedge clk) supply_below <= 1'b0;
    settle(8);
    @(posedge clk) supply_vector_ack <= 1'b1;
    @(posedge clk) supply_vector_ack <= 1'b0;
    rd(SUPPLY_CTRL_OFFSET, 32'h1f, 2'h0);
    wr(SUPPLY_CTRL_OFFSET, 32'h80, 2'h0);
    @(posedge clk) supply_below <= 1'b1;
    settle(8);
    check("bod_level", 32'h1, analog_ctrl_q.brownout_level);
    check("supply_on", 32'h0, analog_ctrl_q.supply_on);
    rd(SUPPLY_CTRL_OFFSET, 32'h80, 2'h0);
    @(posedge clk) supply_below <= 1'b0;
  endtask : supply_test

  task automatic brownout_test;
    @(posedge clk) brownout_below <= 1'b1;
    settle(8);
    check("int_reset", 32'h1, internal_reset_q);
    @(posedge clk) brownout_below <= 1'b0;
    settle(8);
    rd(RESET_STATUS_OFFSET, 32'h2, 2'h0);
    rd(THERMAL_CTRL_OFFSET, 32'h0, 2'h0);
    wr(RESET_STATUS_OFFSET, 32'h2, 2'h0);
    settle(4);
    check("int_reset", 32'h0, internal_reset_q);
    check("armed", 32'h1, analog_ctrl_q.thermal_armed);
  endtask : brownout_test

  task automatic thermal_test;
    wr(SENSOR_CTRL_OFFSET, 32'h4, 2'h0);
    @(posedge clk) over_temp <= 1'b1;
    settle(10);
    check("shutdown", 32'h1, shutdown_q);
    check("int_reset", 32'h1, internal_reset_q);
    check("stage_on", 32'h0, analog_ctrl_q.stage_on);
    @(posedge clk) over_temp <= 1'b0;
    settle(8);
    rd(RESET_STATUS_OFFSET, 32'h1, 2'h0);
    wr(RESET_STATUS_OFFSET, 32'h1, 2'h0);
    wr(THERMAL_CTRL_OFFSET, 32'h1, 2'h0);
    @(posedge clk) over_temp <= 1'b1;
    settle(10);
    check("shutdown", 32'h0, shutdown_q);
    rd(RESET_STATUS_OFFSET, 32'h0, 2'h0);
    @(posedge clk) over_temp <= 1'b0;
  endtask : thermal_test

  // ==========================================================================
  // Verdict and main sequence
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Whole run is a few hundred cycles, generous margin kept
  initial begin
    #500_000;
    mismatches++;
    $display("ERROR watchdog expected done seen hang");
    print_verdict();
  end

  initial begin
    {resetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, level_reached, over_temp, supply_below} = '0;
    {brownout_below, timer2_match, global_irq_enable} = '0;
    supply_vector_ack = 1'b0;
    s_axi_wstrb = 4'hf;
    mismatches = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    settle(2);
    reset_test();
    chan_test();
    conv_test();
    supply_test();
    brownout_test();
    thermal_test();
    print_verdict();
  end
endmodule : tb
